// ### hw/timer_core.sv
// Prescaled 16-bit timer: PWM, capture, compare, gated, capture/compare
`timescale 1ns/1ps
module timer_core
   import timer_pkg::*;
(
   input  wire logic              core_clk_i,
   input  wire logic              sys_rst_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic      [DATA_W-1:0] rdata_o,
   input  wire logic              tmr_in_i,
   output logic                   tmr_out_o,
   output logic                   tmr_out_oe_o,
   output logic                   irq_o
);

   timer_state_s r;
   timer_state_s n;

   logic       en;
   logic       pol;
   logic [2:0] mode;
   logic [6:0] pre_lim;
   logic       tick;
   logic       rise;
   logic       fall;
   logic       sel_edge;
   logic       active;
   logic       at_rld;
   logic       irq_evt;

   always_comb
   begin
      en       = r.ctl1[CTL1_EN_BIT];
      pol      = r.ctl1[CTL1_POL_BIT];
      mode     = r.ctl1[CTL1_MOD_LSB +: 3];
      pre_lim  = 7'((8'h01 << r.ctl1[CTL1_PRE_LSB +: 3]) - 8'h01);
      tick     = en && (r.pre_cnt == pre_lim);
      rise     = r.in_s2 && !r.in_prev;
      fall     = !r.in_s2 && r.in_prev;
      sel_edge = pol ? rise : fall;
      active   = (r.in_s2 == pol);
      at_rld   = (r.cnt == r.rld);
   end

   always_comb
   begin
      n       = r;
      irq_evt = 1'b0;
      // Input synchroniser and edge history
      n.in_s1   = tmr_in_i;
      n.in_s2   = r.in_s1;
      n.in_prev = r.in_s2;
      // Prescaler runs only while enabled
      if (!en || tick)
      begin
         n.pre_cnt = 7'h00;
      end
      else
      begin
         n.pre_cnt = r.pre_cnt + 7'h01;
      end

      // Counting engine
      if (en)
      begin
         case (mode)
            MODE_PWM:
            begin
               if (tick)
               begin
                  if (at_rld)
                  begin
                     irq_evt   = 1'b1;
                     n.cnt     = CNT_RESTART;
                     n.out_lvl = pol;
                  end
                  else
                  begin
                     n.cnt = r.cnt + 16'h0001;
                     if (r.cnt == r.pwm)
                     begin
                        n.out_lvl = !r.out_lvl;
                     end
                  end
               end
            end
            MODE_CAPT:
            begin
               if (tick)
               begin
                  n.cnt = r.cnt + 16'h0001;
                  if (at_rld)
                  begin
                     irq_evt = 1'b1;
                  end
               end
               if (sel_edge)
               begin
                  irq_evt = 1'b1;
               end
            end
            MODE_CMP:
            begin
               if (tick)
               begin
                  n.cnt = r.cnt + 16'h0001;
                  if (at_rld)
                  begin
                     irq_evt   = 1'b1;
                     n.out_lvl = !r.out_lvl;
                  end
               end
            end
            MODE_GATED:
            begin
               if (tick && active)
               begin
                  if (at_rld)
                  begin
                     irq_evt   = 1'b1;
                     n.cnt     = CNT_RESTART;
                     n.out_lvl = !r.out_lvl;
                  end
                  else
                  begin
                     n.cnt = r.cnt + 16'h0001;
                  end
               end
               if (pol ? fall : rise)
               begin
                  irq_evt = 1'b1;
               end
            end
            MODE_CAPCMP:
            begin
               if (!r.cc_run)
               begin
                  if (sel_edge)
                  begin
                     n.cc_run = 1'b1;
                  end
               end
               else if (sel_edge)
               begin
                  irq_evt = 1'b1;
                  n.cnt   = CNT_RESTART;
               end
               else if (tick)
               begin
                  if (at_rld)
                  begin
                     irq_evt = 1'b1;
                     n.cnt   = CNT_RESTART;
                  end
                  else
                  begin
                     n.cnt = r.cnt + 16'h0001;
                  end
               end
            end
            default:
            begin
               n.cnt = r.cnt;
            end
         endcase
      end

      // Register reads, answer in the next cycle
      n.rdata = 8'h00;
      if (rd_i)
      begin
         case (addr_i)
            REG_CNT_HI:
            begin
               n.rdata = r.cnt[15:8];
               if (en)
               begin
                  n.lo_latch = r.cnt[7:0];
               end
            end
            REG_CNT_LO: n.rdata = en ? r.lo_latch : r.cnt[7:0];
            REG_RLD_HI: n.rdata = r.rld[15:8];
            REG_RLD_LO: n.rdata = r.rld[7:0];
            REG_PWM_HI: n.rdata = r.pwm[15:8];
            REG_PWM_LO: n.rdata = r.pwm[7:0];
            REG_CTL0:   n.rdata = r.ctl0;
            REG_CTL1:   n.rdata = r.ctl1;
            default:    n.rdata = 8'h00;
         endcase
      end

      // Register writes
      if (wr_i)
      begin
         case (addr_i)
            REG_CNT_HI: n.cnt[15:8] = wdata_i;
            REG_CNT_LO: n.cnt[7:0]  = wdata_i;
            REG_RLD_HI: n.rld_hold  = wdata_i;
            REG_RLD_LO: n.rld       = {r.rld_hold, wdata_i};
            REG_PWM_HI: n.pwm[15:8] = wdata_i;
            REG_PWM_LO: n.pwm[7:0]  = wdata_i;
            REG_CTL0:   n.ctl0      = wdata_i;
            REG_CTL1:
            begin
               n.ctl1 = wdata_i;
               if (!en && wdata_i[CTL1_EN_BIT])
               begin
                  n.out_lvl = wdata_i[CTL1_POL_BIT];
                  n.cc_run  = 1'b0;
                  n.pre_cnt = 7'h00;
               end
            end
            default:    n.ctl0 = r.ctl0;
         endcase
      end

      // Captures win over a software write of the same cycle
      if (en && sel_edge && ((mode == MODE_CAPT) || ((mode == MODE_CAPCMP) && r.cc_run)))
      begin
         n.pwm = r.cnt;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         r          <= '0;
         r.cnt      <= CNT_RST;
         r.rld      <= RLD_RST;
         r.pwm      <= PWM_RST;
         r.ctl0     <= CTL_RST;
         r.ctl1     <= CTL_RST;
      end
      else
      begin
         r <= n;
      end
   end

   assign rdata_o      = r.rdata;
   assign tmr_out_o    = r.out_lvl;
   assign tmr_out_oe_o = r.ctl0[CTL0_OE_BIT];
   assign irq_o        = irq_evt;

   // Checks
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   sequence s_pwm_reload;
      en && (mode == MODE_PWM) && tick && at_rld && !wr_i;
   endsequence

   a_pwm_reload_restart: assert property (
      s_pwm_reload |-> irq_o ##1 (r.cnt == CNT_RESTART) && (tmr_out_o == pol))
      else $error("PWM reload did not restart at one with start level");

   a_pwm_match_toggle: assert property (
      en && (mode == MODE_PWM) && tick && !at_rld && (r.cnt == r.pwm) && !wr_i
      |=> tmr_out_o != $past(tmr_out_o))
      else $error("PWM match did not toggle output");

   a_cmp_keeps_count: assert property (
      en && (mode == MODE_CMP) && tick && at_rld && !wr_i
      |-> irq_o ##1 (r.cnt == $past(r.cnt) + 16'h0001) && (tmr_out_o != $past(tmr_out_o)))
      else $error("Compare match reset the count or missed toggle");

   a_cmp_wraps_zero: assert property (
      en && (mode == MODE_CMP) && tick && (r.cnt == 16'hFFFF) && !wr_i
      |=> r.cnt == 16'h0000)
      else $error("Compare count did not wrap");

   a_cap_copies_count: assert property (
      en && (mode == MODE_CAPT) && sel_edge |-> irq_o ##1 (r.pwm == $past(r.cnt)))
      else $error("Capture did not copy count");

   a_gate_holds_count: assert property (
      en && (mode == MODE_GATED) && !active && !wr_i |=> $stable(r.cnt))
      else $error("Gated count moved while inactive");

   a_gate_drop_irq: assert property (
      en && (mode == MODE_GATED) && (pol ? fall : rise) |-> irq_o)
      else $error("Gate deassertion gave no interrupt");

   sequence s_cc_first_edge;
      en && (mode == MODE_CAPCMP) && !r.cc_run && sel_edge && !wr_i;
   endsequence

   a_cc_first_quiet: assert property (
      s_cc_first_edge |-> !irq_o ##1 r.cc_run)
      else $error("First capture edge misbehaved");

   a_cc_edge_restart: assert property (
      en && (mode == MODE_CAPCMP) && r.cc_run && sel_edge && !wr_i
      |=> (r.cnt == CNT_RESTART) && (r.pwm == $past(r.cnt)))
      else $error("Capture/compare edge did not restart");

   a_hi_read_latch: assert property (
      rd_i && (addr_i == REG_CNT_HI) && en ##1 rd_i && (addr_i == REG_CNT_LO)
      |=> rdata_o == $past(r.cnt[7:0], 2))
      else $error("Low byte read did not return latched value");

   a_tick_needs_enable: assert property (
      !en |-> !tick ##1 (r.pre_cnt == 7'h00))
      else $error("Prescaler ran while disabled");

   a_start_level: assert property (
      wr_i && (addr_i == REG_CTL1) && !en && wdata_i[CTL1_EN_BIT]
      |=> tmr_out_o == $past(wdata_i[CTL1_POL_BIT]))
      else $error("Enable did not load the start level");

   a_cap_reload_irq: assert property (
      en && (mode == MODE_CAPT) && tick && at_rld && !wr_i
      |-> irq_o ##1 (r.cnt == $past(r.cnt) + 16'h0001))
      else $error("Capture reload gave no interrupt or stopped count");

   a_cap_other_edge: assert property (
      en && (mode == MODE_CAPT) && (pol ? fall : rise) && !wr_i
      |=> $stable(r.pwm))
      else $error("Unselected edge captured the count");

   a_gate_reload: assert property (
      en && (mode == MODE_GATED) && tick && active && at_rld && !wr_i
      |-> irq_o ##1 (r.cnt == CNT_RESTART) && (tmr_out_o != $past(tmr_out_o)))
      else $error("Gated reload did not restart and toggle");

   a_cc_hold_count: assert property (
      en && (mode == MODE_CAPCMP) && !r.cc_run && !wr_i |=> $stable(r.cnt))
      else $error("Capture/compare counted before first edge");

   a_cc_cmp_restart: assert property (
      en && (mode == MODE_CAPCMP) && r.cc_run && !sel_edge && tick && at_rld && !wr_i
      |-> irq_o ##1 (r.cnt == CNT_RESTART))
      else $error("Capture/compare match did not restart");

   a_rld_hold: assert property (
      wr_i && (addr_i == REG_RLD_HI) |=> $stable(r.rld))
      else $error("Reload high byte applied before low byte");

   a_pre_divides: assert property (
      en && tick && (r.ctl1[CTL1_PRE_LSB +: 3] != 3'h0) && !wr_i |=> !tick)
      else $error("Prescaler ticked twice in a row");

endmodule : timer_core

// ### hw/timer_pkg.sv
// Constants, register map and state layout of the prescaled timer
package timer_pkg;

   localparam int unsigned ADDR_W   = 3;
   localparam int unsigned DATA_W   = 8;
   localparam int unsigned CNT_W    = 16;
   localparam int unsigned PRE_W    = 7;

   // Register indices, one byte each
   localparam logic [2:0] REG_CNT_HI   = 3'h0;
   localparam logic [2:0] REG_CNT_LO   = 3'h1;
   localparam logic [2:0] REG_RLD_HI   = 3'h2;
   localparam logic [2:0] REG_RLD_LO   = 3'h3;
   localparam logic [2:0] REG_PWM_HI   = 3'h4;
   localparam logic [2:0] REG_PWM_LO   = 3'h5;
   localparam logic [2:0] REG_CTL0     = 3'h6;
   localparam logic [2:0] REG_CTL1     = 3'h7;

   // Control 1 fields
   localparam int unsigned CTL1_EN_BIT  = 7;
   localparam int unsigned CTL1_POL_BIT = 6;
   localparam int unsigned CTL1_PRE_LSB = 3;
   localparam int unsigned CTL1_MOD_LSB = 0;
   // Control 0 field
   localparam int unsigned CTL0_OE_BIT  = 0;

   // Mode encodings
   localparam logic [2:0] MODE_PWM     = 3'h3;
   localparam logic [2:0] MODE_CAPT    = 3'h4;
   localparam logic [2:0] MODE_CMP     = 3'h5;
   localparam logic [2:0] MODE_GATED   = 3'h6;
   localparam logic [2:0] MODE_CAPCMP  = 3'h7;

   // Reset and restart values
   localparam logic [15:0] CNT_RST     = 16'h0000;
   localparam logic [15:0] RLD_RST     = 16'hFFFF;
   localparam logic [15:0] PWM_RST     = 16'h0000;
   localparam logic [7:0]  CTL_RST     = 8'h00;
   localparam logic [15:0] CNT_RESTART = 16'h0001;

   typedef struct packed {
      logic [15:0] cnt;
      logic [15:0] rld;
      logic [7:0]  rld_hold;
      logic [15:0] pwm;
      logic [7:0]  ctl0;
      logic [7:0]  ctl1;
      logic [7:0]  lo_latch;
      logic        out_lvl;
      logic        in_s1;
      logic        in_s2;
      logic        in_prev;
      logic [6:0]  pre_cnt;
      logic        cc_run;
      logic [7:0]  rdata;
   } timer_state_s;

endpackage : timer_pkg

// ### tb/gpio_pin_model.sv
// Pin-side model: timer input driver and output pad with pull-up
`timescale 1ns/1ps
module gpio_pin_model (
   input  wire logic in_lvl_i,
   input  wire logic tmr_out_i,
   input  wire logic tmr_out_oe_i,
   output logic      tmr_in_o,
   output logic      pad_o
);
   // Input moves off the clock grid, as an outside signal does
   assign #7 tmr_in_o = in_lvl_i;
   // Pull-up holds the pad while the timer does not drive it
   assign pad_o = tmr_out_oe_i ? tmr_out_i : 1'b1;
endmodule : gpio_pin_model

// ### tb/tb_top.sv
// Self-checking bench for the prescaled timer
`timescale 1ns/1ps
module tb_top
   import timer_pkg::*;
;
   logic              core_clk_i = 1'b0;
   logic              sys_rst_i  = 1'b1;
   logic [ADDR_W-1:0] addr_i     = '0;
   logic [DATA_W-1:0] wdata_i    = '0;
   logic              wr_i       = 1'b0;
   logic              rd_i       = 1'b0;
   logic              in_lvl     = 1'b0;
   logic [DATA_W-1:0] rdata_o;
   logic              tmr_in_i, tmr_out_o, tmr_out_oe_o, irq_o, pad;
   int                n_errors   = 0;
   int                n_compared = 0;
   int                n_irq      = 0;

   always #12.5 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) if (irq_o === 1'b1) n_irq <= n_irq + 1;

   timer_core timer_core_inst (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .tmr_in_i(tmr_in_i), .tmr_out_o(tmr_out_o), .tmr_out_oe_o(tmr_out_oe_o),
      .irq_o(irq_o));
   gpio_pin_model gpio_pin_model_inst (.in_lvl_i(in_lvl), .tmr_out_i(tmr_out_o),
      .tmr_out_oe_i(tmr_out_oe_o), .tmr_in_o(tmr_in_i), .pad_o(pad));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask : tick

   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= d;
      @(posedge core_clk_i);
      wr_i    <= 1'b0;
      #1;
   endtask : wr_reg

   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(posedge core_clk_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge core_clk_i);
      rd_i   <= 1'b0;
      #1;
      d = rdata_o;
   endtask : rd_reg

   task automatic wr16(input logic [2:0] a, input logic [15:0] v);
      wr_reg(a, v[15:8]);
      wr_reg(a + 3'h1, v[7:0]);
   endtask : wr16

   task automatic rd16(input logic [2:0] a, output logic [15:0] v);
      // Back-to-back strobes: a count high byte read while enabled latches the low byte
      @(posedge core_clk_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge core_clk_i);
      addr_i <= a + 3'h1;
      #1;
      v[15:8] = rdata_o;
      @(posedge core_clk_i);
      rd_i   <= 1'b0;
      #1;
      v[7:0] = rdata_o;
   endtask : rd16

   task automatic cfg(input logic [2:0] md, input logic pl, input logic [2:0] pre,
                      input logic [15:0] st, input logic [15:0] rl, input logic [15:0] pw);
      wr_reg(REG_CTL1, 8'h00);
      wr_reg(REG_CTL1, {1'b0, pl, pre, md});
      wr16(REG_CNT_HI, st);
      wr16(REG_RLD_HI, rl);
      wr16(REG_PWM_HI, pw);
      wr_reg(REG_CTL0, 8'h01);
      wr_reg(REG_CTL1, {1'b1, pl, pre, md});
   endtask : cfg

   task automatic wait_irq(input int lim, output int n);
      n = 0;
      do
      begin
         tick(1);
         n++;
      end
      while (irq_o !== 1'b1 && n < lim);
   endtask : wait_irq

   // One full period from an interrupt cycle to the next
   task automatic measure(output int per, output int hi);
      per = 0;
      hi  = 0;
      do
      begin
         tick(1);
         per++;
         hi += (pad === 1'b1);
      end
      while (irq_o !== 1'b1 && per < 4000);
   endtask : measure

   task automatic t_reset;
      logic [7:0] exp_v [8] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
      logic [7:0] d;
      for (int i = 0; i < 8; i++)
      begin
         rd_reg(3'(i), d);
         chk(d, exp_v[i]);
      end
      chk(pad, 1'b1);
   endtask : t_reset

   task automatic t_reload;
      logic [7:0]  d;
      logic [15:0] v;
      wr_reg(REG_RLD_HI, 8'h12);
      rd_reg(REG_RLD_HI, d);
      chk(d, 8'hFF);
      wr_reg(REG_RLD_LO, 8'h34);
      rd16(REG_RLD_HI, v);
      chk(v, 16'h1234);
   endtask : t_reload

   task automatic t_pwm;
      int   e, n, per, hi;
      logic pl;
      for (int i = 0; i < 3; i++)
      begin
         e  = (i == 0) ? 0 : (i == 1) ? 2 : 7;
         pl = (i != 0);
         cfg(MODE_PWM, pl, 3'(e), 16'h0008, 16'h000A, 16'h0004);
         chk(pad, pl);
         wait_irq(2000, n);
         chk(n < (10 << e), 1'b1);
         measure(per, hi);
         chk(per, 10 << e);
         chk(hi, (pl ? 4 : 6) << e);
      end
   endtask : t_pwm

   task automatic t_compare;
      int         n, m0;
      logic [7:0] a, b;
      cfg(MODE_CMP, 1'b0, 3'h0, 16'hFFFE, 16'h0003, 16'h0000);
      chk(pad, 1'b0);
      wait_irq(12, n);
      chk(irq_o, 1'b1);
      tick(2);
      chk(pad, 1'b1);
      m0 = n_irq;
      tick(100);
      chk(n_irq - m0, 0);
      rd_reg(REG_CNT_HI, a);
      tick(40);
      rd_reg(REG_CNT_LO, a);
      tick(40);
      rd_reg(REG_CNT_LO, b);
      chk(a, b);
   endtask : t_compare

   task automatic t_capture;
      int          n, m0;
      logic [15:0] v, w;
      cfg(MODE_CAPT, 1'b1, 3'h0, 16'h0001, 16'h0040, 16'h0000);
      wait_irq(100, n);
      chk(irq_o, 1'b1);
      rd16(REG_PWM_HI, v);
      chk(v, 16'h0000);
      @(posedge core_clk_i);
      in_lvl <= 1'b1;
      wait_irq(8, n);
      chk(n <= 5, 1'b1);
      tick(1);
      chk(irq_o, 1'b0);
      rd16(REG_PWM_HI, v);
      chk(v != 16'h0000, 1'b1);
      m0 = n_irq;
      @(posedge core_clk_i);
      in_lvl <= 1'b0;
      tick(10);
      chk(n_irq - m0, 0);
      rd16(REG_PWM_HI, w);
      chk(w, v);
   endtask : t_capture

   task automatic t_capcmp;
      int n, m0;
      cfg(MODE_CAPCMP, 1'b1, 3'h0, 16'h0001, 16'h0040, 16'h0000);
      m0 = n_irq;
      tick(90);
      @(posedge core_clk_i);
      in_lvl <= 1'b1;
      tick(12);
      chk(n_irq - m0, 0);
      @(posedge core_clk_i);
      in_lvl <= 1'b0;
      tick(12);
      @(posedge core_clk_i);
      in_lvl <= 1'b1;
      wait_irq(8, n);
      chk(irq_o, 1'b1);
      wait_irq(100, n);
      chk(n >= 62 && n <= 65, 1'b1);
      wait_irq(100, n);
      chk(n, 16'h0040);
   endtask : t_capcmp

   task automatic t_gated;
      int          per, h1, h2, m0;
      logic [15:0] a, b;
      cfg(MODE_GATED, 1'b0, 3'h0, 16'h0001, 16'h0008, 16'h0000);
      tick(20);
      rd16(REG_CNT_HI, a);
      chk(a, 16'h0001);
      @(posedge core_clk_i);
      in_lvl <= 1'b0;
      wait_irq(40, per);
      measure(per, h1);
      chk(per, 8);
      measure(per, h2);
      chk(h1 + h2, 8);
      @(posedge core_clk_i);
      in_lvl <= 1'b1;
      #1;
      m0 = n_irq;
      tick(14);
      chk(n_irq - m0, 1);
      rd16(REG_CNT_HI, a);
      tick(10);
      rd16(REG_CNT_HI, b);
      chk(a, b);
   endtask : t_gated

   task automatic close_out;
      $display("Compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : close_out

   initial
   begin
      repeat (4) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      t_reset;
      t_reload;
      t_pwm;
      t_compare;
      t_capture;
      t_capcmp;
      t_gated;
      close_out;
   end

   initial
   begin
      #(25 * 60000);
      n_errors++;
      close_out;
   end
endmodule : tb_top
